// File: rtl/host_pins_pkg.sv
// Host pin block constants
package host_pins_pkg;
  // System clock
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  // Reset pin low time
  localparam int RESET_MIN_NS = 2000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Settle wait after release
  localparam int PLL_SETTLE_MS = 150;
  localparam int PLL_SETTLE_CYC = PLL_SETTLE_MS * (CLK_HZ / 1000);
  // Host port geometry
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 3;
  // Attention sources
  localparam int SOCKETS = 8;
  localparam int CAUSES = 4;
  localparam int CAUSE_CONNECT = 0;
  localparam int CAUSE_DISCONNECT = 1;
  localparam int CAUSE_RECEIVE = 2;
  localparam int CAUSE_TIMEOUT = 3;
  // Synchronised pin vector layout
  localparam int PIN_COUNT = 17;
  localparam int PIN_DATA = 0;
  localparam int PIN_HW_RESET_LOW = 8;
  localparam int PIN_AUTONEG = 9;
  localparam int PIN_SERIAL_SEL = 10;
  localparam int PIN_SLEEP = 11;
  localparam int PIN_ADDR0 = 12;
  localparam int PIN_ADDR1 = 13;
  localparam int PIN_IN_WR = 14;
  localparam int PIN_CLK_RD = 15;
  localparam int PIN_SELECT_LOW = 16;
  // Idle levels, reset pin held
  localparam logic [PIN_COUNT-1:0] PIN_SYNC_RST = 17'h1c000;
  // Strap reset values
  localparam logic STRAP_SERIAL_RST = 1'h0;
  localparam logic STRAP_DUPLEX_RST = 1'h0;
  localparam logic STRAP_RATE_RST = 1'h0;
  localparam logic STRAP_AUTONEG_RST = 1'h0;

  typedef enum logic [1:0] {PH_HELD, PH_SETTLE, PH_READY} phase_type;
endpackage : host_pins_pkg

// File: rtl/strap_set_if.sv
// Strap levels in, latched host mode, duplex and rate out, autoneg enable follows its pin
`timescale 1ns/1ps
interface strap_set_if;
  logic capture;
  logic serial_level;
  logic addr0_level;
  logic addr1_level;
  logic autoneg_level;
  logic serial_mode;
  logic full_duplex;
  logic rate_100m;
  logic autoneg_en;

  modport sampler (
    input capture, serial_level, addr0_level, addr1_level, autoneg_level,
    output serial_mode, full_duplex, rate_100m, autoneg_en
  );
  modport user (
    output capture, serial_level, addr0_level, addr1_level, autoneg_level,
    input serial_mode, full_duplex, rate_100m, autoneg_en
  );
endinterface : strap_set_if

// File: rtl/strap_sampler.sv
// Reset-time strap latches for host mode, duplex and rate
`timescale 1ns/1ps
module strap_sampler
  import host_pins_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic reset_i, // Synchronous reset
  strap_set_if.sampler straps // Strap levels and settings
);
  logic serial_mode;
  logic full_duplex;
  logic rate_100m;
  logic autoneg_en;

  // Pins are address lines once released
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      serial_mode <= STRAP_SERIAL_RST;
      full_duplex <= STRAP_DUPLEX_RST;
      rate_100m <= STRAP_RATE_RST;
    end else if (straps.capture) begin
      serial_mode <= straps.serial_level;
      full_duplex <= straps.addr0_level;
      rate_100m <= straps.addr1_level;
    end
  end

  // Autoneg follows its pin
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      autoneg_en <= STRAP_AUTONEG_RST;
    end else begin
      autoneg_en <= straps.autoneg_level;
    end
  end

  assign straps.serial_mode = serial_mode;
  assign straps.full_duplex = full_duplex;
  assign straps.rate_100m = rate_100m;
  assign straps.autoneg_en = autoneg_en;
endmodule : strap_sampler

// File: rtl/attention_ctrl.sv
// Sticky causes, masks and the attention pin
`timescale 1ns/1ps
module attention_ctrl
  import host_pins_pkg::*;
#(
  parameter int NSOCK = SOCKETS
) (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_i, // Synchronous reset
  input wire logic wipe_i, // Held in reset
  input wire logic [NSOCK*CAUSES-1:0] socket_event_i, // Per-socket cause pulses
  input wire logic wake_on_lan_event_i, // Wake-on-LAN pulse
  input wire logic [NSOCK*CAUSES-1:0] socket_clear_i, // Per-socket clear pulses
  input wire logic wake_on_lan_clear_i, // Common register clear pulse
  input wire logic [NSOCK*CAUSES-1:0] socket_mask_i, // 1 enables a socket cause
  input wire logic wake_on_lan_mask_i, // 1 enables wake-on-LAN
  output logic [NSOCK*CAUSES-1:0] socket_flags_o, // Socket event register bits
  output logic common_flag_o, // Common event register bit
  output logic attention_low_o // Attention pin, active low
);
  genvar i;
  generate
    for (i = 0; i < NSOCK*CAUSES; i++) begin : g_flag
      // An event in the clearing cycle survives
      always_ff @(posedge clk_sys_i) begin
        if (reset_i || wipe_i) begin
          socket_flags_o[i] <= 1'h0;
        end else if (socket_event_i[i]) begin
          socket_flags_o[i] <= 1'h1;
        end else if (socket_clear_i[i]) begin
          socket_flags_o[i] <= 1'h0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || wipe_i) begin
      common_flag_o <= 1'h0;
    end else if (wake_on_lan_event_i) begin
      common_flag_o <= 1'h1;
    end else if (wake_on_lan_clear_i) begin
      common_flag_o <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || wipe_i) begin
      attention_low_o <= 1'h1;
    end else begin
      attention_low_o <= ~(|(socket_flags_o & socket_mask_i) |
                           (common_flag_o & wake_on_lan_mask_i));
    end
  end
endmodule : attention_ctrl

// File: rtl/host_pins_and_reset_straps.sv
// Host pins: reset tracking, straps, serial slave, indirect port, attention
`timescale 1ns/1ps
module host_pins_and_reset_straps
  import host_pins_pkg::*;
#(
  parameter int SETTLE_CYC = PLL_SETTLE_CYC,
  parameter int NSOCK = SOCKETS
) (
  input wire logic clk_sys_i, // System clock, 10 MHz
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic hw_reset_low_i, // Hardware reset pin, active low
  input wire logic select_low_i, // Chip select pin, active low
  input wire logic serial_clock_or_read_strobe_i, // Serial clock or read strobe
  input wire logic serial_in_or_write_strobe_i, // Serial data in or write strobe
  input wire logic addr0_duplex_strap_i, // Address bit 0, duplex strap in reset
  input wire logic addr1_rate_strap_i, // Address bit 1, rate strap in reset
  input wire logic [DATA_W-1:0] host_data_bus_i, // Data bus level in
  output logic [DATA_W-1:0] host_data_bus_o, // Data bus drive value
  output logic host_data_bus_oe_o, // Data bus output enable
  output logic serial_out_o, // Serial data out
  output logic attention_low_o, // Attention pin, active low
  input wire logic sleep_request_i, // Power-down pin, active high
  input wire logic serial_host_select_i, // Host mode strap
  input wire logic autoneg_strap_i, // Auto-negotiation strap
  output logic serial_mode_o, // Host mode, 1 serial
  output logic full_duplex_o, // Duplex, 1 full
  output logic rate_100m_o, // Rate, 1 100M
  output logic autoneg_en_o, // Auto-negotiation enable
  output logic power_down_o, // Power-down mode active
  output logic in_hw_reset_o, // Held in reset
  output logic device_ready_o, // Host access open
  output logic short_reset_o, // Last reset too short
  output logic access_refused_o, // Pulse: early access
  output logic [ADDR_W-1:0] host_addr_o, // Last indirect location
  output logic [DATA_W-1:0] host_wdata_o, // Indirect write data
  output logic host_write_o, // Pulse: indirect write taken
  output logic host_read_o, // Pulse: indirect read started
  input wire logic [DATA_W-1:0] host_rdata_i, // Read data for host_addr_o
  output logic [DATA_W-1:0] serial_rx_byte_o, // Serial byte received
  output logic serial_rx_valid_o, // Pulse: serial byte complete
  input wire logic [DATA_W-1:0] serial_tx_byte_i, // Next byte to send
  output logic serial_tx_take_o, // Pulse: byte loaded
  input wire logic [NSOCK*CAUSES-1:0] socket_event_i, // Per-socket cause pulses
  input wire logic wake_on_lan_event_i, // Wake-on-LAN pulse
  input wire logic [NSOCK*CAUSES-1:0] socket_clear_i, // Per-socket clear pulses
  input wire logic wake_on_lan_clear_i, // Common register clear pulse
  input wire logic [NSOCK*CAUSES-1:0] socket_mask_i, // Socket cause enables
  input wire logic wake_on_lan_mask_i, // Wake-on-LAN enable
  output logic [NSOCK*CAUSES-1:0] socket_flags_o, // Socket event register bits
  output logic common_flag_o // Common event register bit
);
  function automatic logic rose(input logic prev, input logic now);
    rose = ~prev & now;
  endfunction : rose

  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction : fell

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_prev;

  assign pin_raw = {select_low_i, serial_clock_or_read_strobe_i, serial_in_or_write_strobe_i,
                    addr1_rate_strap_i, addr0_duplex_strap_i, sleep_request_i,
                    serial_host_select_i, autoneg_strap_i, hw_reset_low_i, host_data_bus_i};

  genvar p;
  generate
    for (p = 0; p < PIN_COUNT; p++) begin : g_sync
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          pin_meta[p] <= PIN_SYNC_RST[p];
          pin_sync[p] <= PIN_SYNC_RST[p];
          pin_prev[p] <= PIN_SYNC_RST[p];
        end else begin
          pin_meta[p] <= pin_raw[p];
          pin_sync[p] <= pin_meta[p];
          pin_prev[p] <= pin_sync[p];
        end
      end
    end
  endgenerate

  logic sel_now;
  logic clk_rd_now;
  logic clk_rd_prev;
  logic in_wr_now;
  logic in_wr_prev;
  logic [ADDR_W-1:0] addr_now;
  logic [DATA_W-1:0] data_now;

  assign sel_now = ~pin_sync[PIN_SELECT_LOW];
  assign clk_rd_now = pin_sync[PIN_CLK_RD];
  assign clk_rd_prev = pin_prev[PIN_CLK_RD];
  assign in_wr_now = pin_sync[PIN_IN_WR];
  assign in_wr_prev = pin_prev[PIN_IN_WR];
  assign addr_now = {pin_sync[PIN_ADDR1], pin_sync[PIN_ADDR0]};
  assign data_now = pin_sync[PIN_DATA +: DATA_W];

  ////////////////////////////////////////////////////////////////////////////
  // Hardware reset tracking and settle wait

  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);
  localparam int HOLD_W = $clog2(RESET_MIN_CYC + 1);

  phase_type phase;
  logic [HOLD_W-1:0] hold_count;
  logic [SETTLE_W-1:0] settle_count;
  logic pin_held;

  assign pin_held = ~pin_sync[PIN_HW_RESET_LOW];

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase <= PH_HELD;
    end else begin
      unique case (phase)
        PH_HELD: if (!pin_held) phase <= PH_SETTLE;
        PH_SETTLE: begin
          if (pin_held) begin
            phase <= PH_HELD;
          end else if (settle_count == SETTLE_W'(SETTLE_CYC - 1)) begin
            phase <= PH_READY;
          end
        end
        PH_READY: if (pin_held) phase <= PH_HELD;
      endcase
    end
  end

  // Saturating low-time count
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || phase != PH_HELD) begin
      hold_count <= '0;
    end else if (hold_count != HOLD_W'(RESET_MIN_CYC)) begin
      hold_count <= hold_count + HOLD_W'(1);
    end
  end

  // Short pulses still reset, only flagged
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      short_reset_o <= 1'h0;
    end else if (phase == PH_HELD && !pin_held) begin
      short_reset_o <= hold_count < HOLD_W'(RESET_MIN_CYC);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || phase != PH_SETTLE) begin
      settle_count <= '0;
    end else begin
      settle_count <= settle_count + SETTLE_W'(1);
    end
  end

  assign in_hw_reset_o = (phase == PH_HELD);
  assign device_ready_o = (phase == PH_READY);

  ////////////////////////////////////////////////////////////////////////////
  // Straps and power-down

  strap_set_if straps ();

  assign straps.capture = in_hw_reset_o;
  assign straps.serial_level = pin_sync[PIN_SERIAL_SEL];
  assign straps.addr0_level = pin_sync[PIN_ADDR0];
  assign straps.addr1_level = pin_sync[PIN_ADDR1];
  assign straps.autoneg_level = pin_sync[PIN_AUTONEG];

  strap_sampler u_straps (
    .clk_sys_i (clk_sys_i),
    .reset_i (reset_i),
    .straps (straps)
  );

  assign serial_mode_o = straps.serial_mode;
  assign full_duplex_o = straps.full_duplex;
  assign rate_100m_o = straps.rate_100m;
  assign autoneg_en_o = straps.autoneg_en;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      power_down_o <= 1'h0;
    end else begin
      power_down_o <= pin_sync[PIN_SLEEP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host access gating

  logic serial_sel;
  logic indirect_sel;

  assign serial_sel = device_ready_o & serial_mode_o & sel_now;
  assign indirect_sel = device_ready_o & ~serial_mode_o & sel_now;

  // Early strobes dropped, not queued
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      access_refused_o <= 1'h0;
    end else begin
      access_refused_o <= ~device_ready_o & ~in_hw_reset_o & sel_now &
                          (fell(clk_rd_prev, clk_rd_now) | rose(in_wr_prev, in_wr_now));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave, clock idle low, sample on rise, shift on fall

  logic [DATA_W-1:0] rx_shift;
  logic [DATA_W-1:0] tx_shift;
  logic [BIT_CNT_W-1:0] bit_count;
  logic reload;
  logic serial_sel_prev;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      serial_sel_prev <= 1'h0;
    end else begin
      serial_sel_prev <= serial_sel;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !serial_sel) begin
      rx_shift <= '0;
      bit_count <= '0;
      reload <= 1'h0;
      serial_rx_valid_o <= 1'h0;
    end else begin
      serial_rx_valid_o <= 1'h0;
      if (rose(clk_rd_prev, clk_rd_now)) begin
        rx_shift <= {rx_shift[DATA_W-2:0], in_wr_now};
        bit_count <= bit_count + BIT_CNT_W'(1);
        if (bit_count == BIT_CNT_W'(DATA_W - 1)) begin
          serial_rx_valid_o <= 1'h1;
          reload <= 1'h1;
        end
      end else if (fell(clk_rd_prev, clk_rd_now)) begin
        reload <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      serial_rx_byte_o <= '0;
    end else if (serial_sel && rose(clk_rd_prev, clk_rd_now) &&
                 bit_count == BIT_CNT_W'(DATA_W - 1)) begin
      serial_rx_byte_o <= {rx_shift[DATA_W-2:0], in_wr_now};
    end
  end

  // First bit stands before the first rise
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !serial_sel) begin
      tx_shift <= '0;
      serial_tx_take_o <= 1'h0;
    end else begin
      serial_tx_take_o <= 1'h0;
      if (!serial_sel_prev || (reload && fell(clk_rd_prev, clk_rd_now))) begin
        tx_shift <= serial_tx_byte_i;
        serial_tx_take_o <= 1'h1;
      end else if (fell(clk_rd_prev, clk_rd_now)) begin
        tx_shift <= {tx_shift[DATA_W-2:0], 1'h0};
      end
    end
  end

  assign serial_out_o = tx_shift[DATA_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Indirect parallel port

  logic reading;

  assign reading = indirect_sel & ~clk_rd_now;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      host_addr_o <= '0;
      host_wdata_o <= '0;
      host_write_o <= 1'h0;
      host_read_o <= 1'h0;
    end else begin
      host_write_o <= 1'h0;
      host_read_o <= 1'h0;
      if (indirect_sel && rose(in_wr_prev, in_wr_now)) begin
        host_addr_o <= addr_now;
        host_wdata_o <= data_now;
        host_write_o <= 1'h1;
      end else if (indirect_sel && fell(clk_rd_prev, clk_rd_now)) begin
        host_addr_o <= addr_now;
        host_read_o <= 1'h1;
      end
    end
  end

  // Data lags the strobe by two sync stages and one output register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !reading) begin
      host_data_bus_o <= '0;
      host_data_bus_oe_o <= 1'h0;
    end else begin
      host_data_bus_o <= host_rdata_i;
      host_data_bus_oe_o <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attention

  attention_ctrl #(
    .NSOCK (NSOCK)
  ) u_attention (
    .clk_sys_i (clk_sys_i),
    .reset_i (reset_i),
    .wipe_i (in_hw_reset_o),
    .socket_event_i (socket_event_i),
    .wake_on_lan_event_i (wake_on_lan_event_i),
    .socket_clear_i (socket_clear_i),
    .wake_on_lan_clear_i (wake_on_lan_clear_i),
    .socket_mask_i (socket_mask_i),
    .wake_on_lan_mask_i (wake_on_lan_mask_i),
    .socket_flags_o (socket_flags_o),
    .common_flag_o (common_flag_o),
    .attention_low_o (attention_low_o)
  );
endmodule : host_pins_and_reset_straps

// File: tb/host_pins_checker.sv
// Concurrent checks on the host pin block ports
`timescale 1ns/1ps
module host_pins_checker
  import host_pins_pkg::*;
#(
  parameter int NSOCK = SOCKETS
) (
  input wire logic clk_sys_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic select_low_i, // Select pin
  input wire logic sleep_request_i, // Sleep pin
  input wire logic autoneg_strap_i, // Autoneg pin
  input wire logic [NSOCK*CAUSES-1:0] socket_event_i, // Events
  input wire logic wake_on_lan_event_i, // Wake event
  input wire logic [NSOCK*CAUSES-1:0] socket_clear_i, // Clears
  input wire logic wake_on_lan_clear_i, // Wake clear
  input wire logic [NSOCK*CAUSES-1:0] socket_mask_i, // Masks
  input wire logic wake_on_lan_mask_i, // Wake mask
  input wire logic [NSOCK*CAUSES-1:0] socket_flags_o, // Flags
  input wire logic common_flag_o, // Wake flag
  input wire logic attention_low_o, // Attention
  input wire logic serial_out_o, // Serial out
  input wire logic serial_mode_o, // Mode
  input wire logic full_duplex_o, // Duplex
  input wire logic rate_100m_o, // Rate
  input wire logic autoneg_en_o, // Autoneg
  input wire logic power_down_o, // Power-down
  input wire logic in_hw_reset_o, // Held
  input wire logic device_ready_o, // Ready
  input wire logic host_write_o, // Write pulse
  input wire logic host_read_o, // Read pulse
  input wire logic host_data_bus_oe_o // Bus enable
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////
  property p_att_map;
    !in_hw_reset_o ##1 !in_hw_reset_o |-> attention_low_o == !((|$past(socket_flags_o
      & socket_mask_i)) || $past(common_flag_o & wake_on_lan_mask_i));
  endproperty
  a_att_map: assert property (p_att_map)
    else $error("attention mismatch");
  property p_flag_set;
    !in_hw_reset_o |=> (socket_flags_o & $past(socket_event_i)) == $past(socket_event_i)
      && (common_flag_o || !$past(wake_on_lan_event_i));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set");
  property p_clear;
    !in_hw_reset_o |=> (socket_flags_o & $past(socket_clear_i & ~socket_event_i)) == '0
      && !(common_flag_o && $past(wake_on_lan_clear_i && !wake_on_lan_event_i));
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared");
  property p_sleep;
    $stable(sleep_request_i) [*5] |-> power_down_o == sleep_request_i;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("power-down mismatch");
  property p_autoneg;
    $stable(autoneg_strap_i) [*5] ##0 !$past(reset_i, 3) |-> autoneg_en_o == autoneg_strap_i;
  endproperty
  a_autoneg: assert property (p_autoneg)
    else $error("autoneg mismatch");
  property p_strap_hold;
    !in_hw_reset_o && !$past(in_hw_reset_o) |->
      $stable({serial_mode_o, full_duplex_o, rate_100m_o});
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap changed");
  property p_write;
    host_write_o |-> device_ready_o && !serial_mode_o ##1 !host_write_o;
  endproperty
  a_write: assert property (p_write)
    else $error("stray write pulse");
  property p_read;
    host_read_o |-> !serial_mode_o ##[0:1] host_data_bus_oe_o;
  endproperty
  a_read: assert property (p_read)
    else $error("bus not driven");
  property p_serial_idle;
    select_low_i [*4] |-> !serial_out_o;
  endproperty
  a_serial_idle: assert property (p_serial_idle)
    else $error("serial out not idle");
endmodule : host_pins_checker

// File: tb/host_mcu_model.sv
// Host microcontroller model driving the shared host pins
`timescale 1ns/1ps
module host_mcu_model (
  input wire logic clk_sys_i, // Clock
  input wire logic [7:0] bus_i, // Data wire level
  input wire logic serial_out_i, // Device serial out
  output logic hw_reset_low_o, // Reset pin
  output logic select_low_o, // Select pin
  output logic clk_rd_o, // Clock or read strobe
  output logic in_wr_o, // Data or write strobe
  output logic [1:0] addr_o, // Address and strap pins
  output logic [7:0] data_o // Data drive
);
  initial begin
    hw_reset_low_o = 1'h0;
    select_low_o = 1'h1;
    clk_rd_o = 1'h1;
    in_wr_o = 1'h1;
    addr_o = 2'h0;
    data_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // Straps held past release
  task automatic hw_reset(input int n, input logic [1:0] straps);
    @(negedge clk_sys_i);
    hw_reset_low_o = 1'h0;
    addr_o = straps;
    repeat (n) @(negedge clk_sys_i);
    hw_reset_low_o = 1'h1;
    repeat (4) @(negedge clk_sys_i);
  endtask : hw_reset
  task automatic write(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    select_low_o = 1'h0;
    addr_o = a;
    data_o = d;
    in_wr_o = 1'h0;
    repeat (3) @(negedge clk_sys_i);
    in_wr_o = 1'h1;
    repeat (3) @(negedge clk_sys_i);
    select_low_o = 1'h1;
    data_o = ~d;
  endtask : write
  task automatic read(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    select_low_o = 1'h0;
    addr_o = a;
    clk_rd_o = 1'h0;
    repeat (6) @(negedge clk_sys_i);
    d = bus_i;
    clk_rd_o = 1'h1;
    repeat (3) @(negedge clk_sys_i);
    select_low_o = 1'h1;
  endtask : read
  // Mode 0, clock parked low
  task automatic spi(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge clk_sys_i);
    clk_rd_o = 1'h0;
    @(negedge clk_sys_i);
    select_low_o = 1'h0;
    repeat (6) @(negedge clk_sys_i);
    for (int i = 7; i >= 0; i--) begin
      in_wr_o = tx[i];
      repeat (4) @(negedge clk_sys_i);
      rx[i] = serial_out_i;
      clk_rd_o = 1'h1;
      repeat (4) @(negedge clk_sys_i);
      clk_rd_o = 1'h0;
    end
    in_wr_o = ~tx[0];
    repeat (4) @(negedge clk_sys_i);
    select_low_o = 1'h1;
  endtask : spi
endmodule : host_mcu_model

// File: tb/host_pins_and_reset_straps_bench.sv
// Self-checking bench for the host pin and reset strap block
`timescale 1ns/1ps
module host_pins_and_reset_straps_bench;
  import host_pins_pkg::*;
  localparam int NS = 8;
  typedef struct packed {logic [1:0] a; logic [7:0] w; logic [7:0] r;} row_type;
  row_type rows [4] = '{'{2'h0, 8'h5a, 8'hc3}, '{2'h1, 8'ha5, 8'h3c},
    '{2'h2, 8'hff, 8'h00}, '{2'h3, 8'h00, 8'hff}};
  logic clk_sys_i = 1'h0;
  logic reset_i, hw_reset_low_i, select_low_i, serial_clock_or_read_strobe_i;
  logic serial_in_or_write_strobe_i, addr0_duplex_strap_i, addr1_rate_strap_i;
  logic sleep_request_i, serial_host_select_i, autoneg_strap_i, host_data_bus_oe_o;
  logic serial_out_o, attention_low_o, serial_mode_o, full_duplex_o, rate_100m_o;
  logic autoneg_en_o, power_down_o, in_hw_reset_o, device_ready_o, short_reset_o;
  logic access_refused_o, host_write_o, host_read_o, serial_rx_valid_o, serial_tx_take_o;
  logic wake_on_lan_event_i, wake_on_lan_clear_i, wake_on_lan_mask_i, common_flag_o;
  logic [7:0] host_data_bus_i, host_data_bus_o, host_wdata_o, host_rdata_i, mdata, got;
  logic [7:0] serial_rx_byte_o, serial_tx_byte_i;
  logic [1:0] host_addr_o, maddr;
  logic [NS*CAUSES-1:0] socket_event_i, socket_clear_i, socket_mask_i, socket_flags_o;
  logic [32:0] v;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_wr = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (host_write_o === 1'h1) n_wr++;
  assign {addr1_rate_strap_i, addr0_duplex_strap_i} = maddr;
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : mdata;
  host_pins_and_reset_straps #(.SETTLE_CYC(50), .NSOCK(NS)) dut (.*);
  host_mcu_model mcu (.clk_sys_i(clk_sys_i), .bus_i(host_data_bus_i),
    .serial_out_i(serial_out_o), .hw_reset_low_o(hw_reset_low_i),
    .select_low_o(select_low_i), .clk_rd_o(serial_clock_or_read_strobe_i),
    .in_wr_o(serial_in_or_write_strobe_i), .addr_o(maddr), .data_o(mdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] seen);
    tests_run++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask : check
  wire [5:0] hits = {serial_tx_take_o, device_ready_o, serial_rx_valid_o, access_refused_o,
    host_read_o, host_write_o};
  task automatic wait_sig(input int k);
    int n = 0;
    while (hits[k] !== 1'h1) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > 200) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask : wait_sig
  task automatic pulse(input logic [32:0] p, input logic c);
    @(negedge clk_sys_i);
    if (c) {wake_on_lan_clear_i, socket_clear_i} = p;
    else {wake_on_lan_event_i, socket_event_i} = p;
    @(negedge clk_sys_i);
    {wake_on_lan_clear_i, socket_clear_i, wake_on_lan_event_i, socket_event_i} = '0;
    repeat (3) @(negedge clk_sys_i);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_i, sleep_request_i, serial_host_select_i, autoneg_strap_i} = 4'h9;
    {host_rdata_i, serial_tx_byte_i} = '0;
    {wake_on_lan_clear_i, socket_clear_i, wake_on_lan_event_i, socket_event_i} = '0;
    {wake_on_lan_mask_i, socket_mask_i} = '1;
    repeat (8) @(negedge clk_sys_i);
    reset_i = 1'h0;
    mcu.hw_reset(25, 2'h1);
    fork
      mcu.write(2'h0, 8'h11);
      wait_sig(2);
    join
    check("early write", 0, n_wr);
    wait_sig(4);
    repeat (3) @(negedge clk_sys_i);
    check("straps", 5'h08, {serial_mode_o, full_duplex_o, rate_100m_o, short_reset_o,
      in_hw_reset_o});
    foreach (rows[i]) begin
      @(negedge clk_sys_i);
      host_rdata_i = rows[i].r;
      fork
        mcu.write(rows[i].a, rows[i].w);
        wait_sig(0);
      join
      check("write addr", rows[i].a, host_addr_o);
      check("write data", rows[i].w, host_wdata_o);
      fork
        mcu.read(rows[i].a, got);
        wait_sig(1);
      join
      check("read data", rows[i].r, got);
      check("read addr", rows[i].a, host_addr_o);
    end
    check("duplex held", 1, full_duplex_o);
    for (int i = 0; i < 5; i++) begin
      v = (i < 4) ? 33'h1 << (20 + i) : 33'h100000000;
      pulse(v, 1'h0);
      check("attention", 0, attention_low_o);
      check("flags", v, {common_flag_o, socket_flags_o});
      pulse(v, 1'h1);
      check("released", 1, attention_low_o);
      {wake_on_lan_mask_i, socket_mask_i} = ~v;
      pulse(v, 1'h0);
      check("masked", 1, attention_low_o);
      check("masked flag", v, {common_flag_o, socket_flags_o});
      pulse(v, 1'h1);
      {wake_on_lan_mask_i, socket_mask_i} = '1;
    end
    {sleep_request_i, autoneg_strap_i} = 2'h2;
    repeat (6) @(negedge clk_sys_i);
    check("sleep", 2'h2, {power_down_o, autoneg_en_o});
    {sleep_request_i, autoneg_strap_i} = 2'h1;
    repeat (6) @(negedge clk_sys_i);
    check("wake", 2'h1, {power_down_o, autoneg_en_o});
    serial_host_select_i = 1'h1;
    mcu.hw_reset(10, 2'h2);
    wait_sig(4);
    @(negedge clk_sys_i);
    serial_host_select_i = 1'h0;
    repeat (3) @(negedge clk_sys_i);
    check("serial straps", 5'h16, {serial_mode_o, full_duplex_o, rate_100m_o,
      short_reset_o, in_hw_reset_o});
    serial_tx_byte_i = 8'ha5;
    fork
      mcu.spi(8'h3c, got);
      wait_sig(3);
      wait_sig(5);
    join
    check("serial rx", 8'h3c, serial_rx_byte_o);
    check("serial tx", 8'ha5, got);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    end_of_test();
  end
endmodule : host_pins_and_reset_straps_bench
bind host_pins_and_reset_straps host_pins_checker #(.NSOCK(NSOCK)) chk (.*);
